// >>> design/mcb_defines.svh
// shared offsets, field positions and reset values for the check bank block
`ifndef MCB_DEFINES_SVH
`define MCB_DEFINES_SVH

`define MCB_NBANKS 4
`define MCB_VECTOR 8'h12

`define MCB_A_CAP 12'h000
`define MCB_A_GSTATE 12'h004
`define MCB_A_CTL4 12'h008
`define MCB_A_LTYPE 12'h00c
`define MCB_A_LLOC 12'h010
`define MCB_BANK_BASE 12'h400
`define MCB_BANK_STRIDE 12'h010

`define MCB_R_CTL 2'h0
`define MCB_R_STATUS 2'h1
`define MCB_R_ADDR 2'h2
`define MCB_R_MISC 2'h3

`define MCB_ST_GOOD 31
`define MCB_ST_LOST 30
`define MCB_ST_NC 29
`define MCB_ST_EXTRA_INFO_PRESENT 27
`define MCB_ST_FAULT_LOCATION_PRESENT 26
`define MCB_ST_PCC 25

`define MCB_GS_RIP 0
`define MCB_GS_EIP 1
`define MCB_GS_CIP 2

`define MCB_CTL4_MCE 0
`define MCB_BCTL_EN 0
`define MCB_BANK_CTL_RST 32'h00000001

`endif

// >>> design/mcb_pkg.sv
// types shared by the check bank modules
package mcb_pkg;
    typedef struct packed {
        logic [15:0] code;
        logic corrected;
        logic ctx_corrupt;
        logic addr_valid;
        logic [31:0] addr;
        logic misc_valid;
        logic [31:0] misc;
    } mcb_err_s;

    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] status;
        logic [31:0] addr;
        logic [31:0] misc;
    } mcb_bank_s;

    typedef struct packed {
        logic exc;
        logic shut;
    } mcb_raise_s;

    typedef struct packed {
        logic [2:0] gstate;
        logic check_exception_enable_bit;
        logic [31:0] prdata;
        logic slverr;
    } mcb_top_s;
endpackage

// >>> design/mcb_bank_if.sv
// link between the register front end and one error bank
interface mcb_bank_if import mcb_pkg::*; ();
    logic hit;
    mcb_err_s err;
    logic wr_en;
    logic [1:0] wr_sel;
    logic [31:0] wr_data;
    logic [31:0] ctl;
    logic [31:0] status;
    logic [31:0] addr;
    logic [31:0] misc;
    logic raise;

    modport bank (input hit, err, wr_en, wr_sel, wr_data, output ctl, status, addr, misc, raise);
    modport host (output hit, err, wr_en, wr_sel, wr_data, input ctl, status, addr, misc, raise);
endinterface

// >>> design/mcb_bank.sv
// one error-reporting bank: control, state, fault location and extra info words
`include "mcb_defines.svh"
module mcb_bank import mcb_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_b,
    mcb_bank_if.bank bif
);
    mcb_bank_s s_q;
    mcb_bank_s s_d;
    logic lost;

    always_comb begin
        s_d = s_q;
        lost = 1'b0;
        if (bif.wr_en) begin
            case (bif.wr_sel)
                `MCB_R_CTL: s_d.ctl = bif.wr_data;
                `MCB_R_STATUS: s_d.status = bif.wr_data;
                `MCB_R_ADDR: s_d.addr = bif.wr_data;
                default: s_d.misc = bif.wr_data;
            endcase
        end
        // error applied after the write so a same-cycle error is never lost
        if (bif.hit) begin
            lost = s_d.status[`MCB_ST_GOOD] | s_d.status[`MCB_ST_LOST];
            // an uncorrected error may displace a corrected one; older info is then gone
            if (!s_d.status[`MCB_ST_GOOD] || (!s_d.status[`MCB_ST_NC] && !bif.err.corrected)) begin
                s_d.status = '0;
                s_d.status[15:0] = bif.err.code;
                s_d.status[`MCB_ST_GOOD] = 1'b1;
                s_d.status[`MCB_ST_NC] = ~bif.err.corrected;
                s_d.status[`MCB_ST_PCC] = bif.err.ctx_corrupt;
                s_d.status[`MCB_ST_FAULT_LOCATION_PRESENT] = bif.err.addr_valid;
                s_d.status[`MCB_ST_EXTRA_INFO_PRESENT] = bif.err.misc_valid;
                if (bif.err.addr_valid) begin
                    s_d.addr = bif.err.addr;
                end
                if (bif.err.misc_valid) begin
                    s_d.misc = bif.err.misc;
                end
            end
            s_d.status[`MCB_ST_LOST] = lost;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.ctl <= `MCB_BANK_CTL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // corrected errors are only logged for polling
    assign bif.raise = bif.hit & ~bif.err.corrected & s_q.ctl[`MCB_BCTL_EN];
    assign bif.ctl = s_q.ctl;
    assign bif.status = s_q.status;
    assign bif.addr = s_q.addr;
    assign bif.misc = s_q.misc;
endmodule

// >>> design/mcb_raise.sv
// exception delivery and recursion shutdown
module mcb_raise import mcb_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic req,
    input wire logic enable,
    input wire logic busy,
    output logic take,
    output logic exc,
    output logic shut
);
    mcb_raise_s s_q;
    mcb_raise_s s_d;
    logic recurse;

    assign take = req & enable & ~busy & ~s_q.shut;
    assign recurse = req & enable & busy & ~s_q.shut;

    always_comb begin
        s_d = s_q;
        s_d.exc = take;
        // shutdown holds until reset; no further exceptions leave the block
        s_d.shut = s_q.shut | recurse;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign exc = s_q.exc;
    assign shut = s_q.shut;
endmodule

// >>> design/mcb_machine_check.sv
// check bank reporting top: apb registers, global state, banks and exception raise
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`include "mcb_defines.svh"
module mcb_machine_check import mcb_pkg::*; #(
    parameter int NBANKS = `MCB_NBANKS,
    parameter int ADDR_W = 12
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic err_valid,
    input wire logic [$clog2(NBANKS)-1:0] err_bank,
    input wire logic [15:0] err_code,
    input wire logic err_corrected,
    input wire logic err_ctx_corrupt,
    input wire logic err_addr_valid,
    input wire logic [31:0] err_addr,
    input wire logic err_misc_valid,
    input wire logic [31:0] err_misc,
    input wire logic err_restart_ok,
    input wire logic err_ip_related,
    output logic check_exc,
    output logic [7:0] check_vector,
    output logic shutdown
);
    localparam int BW = $clog2(NBANKS);
    localparam logic [7:0] NB8 = 8'(NBANKS);
    localparam logic [ADDR_W-1:0] BASE = ADDR_W'(`MCB_BANK_BASE);
    localparam logic [ADDR_W-1:0] SPAN = ADDR_W'(NBANKS * `MCB_BANK_STRIDE);

    mcb_top_s s_q;
    mcb_top_s s_d;
    mcb_err_s err_w;

    logic setup;
    logic acc_wr;
    logic take;
    logic any_raise;
    logic [31:0] rd_word;
    logic rd_err;
    logic [31:0] bk_rd [NBANKS];
    logic [31:0] bk_st [NBANKS];
    logic [NBANKS-1:0] bk_raise;
    logic [NBANKS-1:0] bk_wr;

    // bank window decode, shared by the read and write paths
    function automatic logic in_banks(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - BASE;
        in_banks = (a >= BASE) && (off < SPAN);
    endfunction

    function automatic logic [BW-1:0] bank_of(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - BASE;
        bank_of = off[4 +: BW];
    endfunction

    assign setup = psel & ~penable;
    assign acc_wr = psel & penable & pwrite & ~s_q.slverr;

    always_comb begin
        err_w.code = err_code;
        err_w.corrected = err_corrected;
        err_w.ctx_corrupt = err_ctx_corrupt;
        err_w.addr_valid = err_addr_valid;
        err_w.addr = err_addr;
        err_w.misc_valid = err_misc_valid;
        err_w.misc = err_misc;
    end

    mcb_bank_if bif [NBANKS] ();

    for (genvar g = 0; g < NBANKS; g++) begin : g_bank
        assign bif[g].hit = err_valid & (err_bank == BW'(g));
        assign bif[g].err = err_w;
        assign bif[g].wr_en = acc_wr & in_banks(paddr) & (bank_of(paddr) == BW'(g));
        assign bif[g].wr_sel = paddr[3:2];
        assign bif[g].wr_data = pwdata;
        assign bk_raise[g] = bif[g].raise;
        assign bk_wr[g] = bif[g].wr_en;
        assign bk_st[g] = bif[g].status;

        always_comb begin
            case (paddr[3:2])
                `MCB_R_CTL: bk_rd[g] = bif[g].ctl;
                `MCB_R_STATUS: bk_rd[g] = bif[g].status;
                `MCB_R_ADDR: bk_rd[g] = bif[g].addr;
                default: bk_rd[g] = bif[g].misc;
            endcase
        end

        mcb_bank u_bank (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .bif(bif[g])
        );
    end

    assign any_raise = |bk_raise;

    mcb_raise u_raise (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .req(any_raise),
        .enable(s_q.check_exception_enable_bit),
        .busy(s_q.gstate[`MCB_GS_CIP]),
        .take(take),
        .exc(check_exc),
        .shut(shutdown)
    );

    // read mux; unaligned or unmapped addresses answer with pslverr
    always_comb begin
        rd_word = 32'h00000000;
        rd_err = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            rd_err = 1'b1;
        end else if (in_banks(paddr)) begin
            rd_word = bk_rd[bank_of(paddr)];
        end else begin
            case (paddr)
                ADDR_W'(`MCB_A_CAP): rd_word = {24'h000000, NB8};
                ADDR_W'(`MCB_A_GSTATE): rd_word = {29'h00000000, s_q.gstate};
                ADDR_W'(`MCB_A_CTL4): rd_word = {31'h00000000, s_q.check_exception_enable_bit};
                // legacy words carry nothing once full banks exist
                ADDR_W'(`MCB_A_LTYPE): rd_word = 32'h00000000;
                ADDR_W'(`MCB_A_LLOC): rd_word = 32'h00000000;
                default: rd_err = 1'b1;
            endcase
        end
    end

    always_comb begin
        s_d = s_q;
        // read data is captured in setup so the access cycle answers from a flop
        if (setup) begin
            s_d.prdata = rd_word;
            s_d.slverr = rd_err;
        end
        if (acc_wr) begin
            case (paddr)
                ADDR_W'(`MCB_A_GSTATE): s_d.gstate = pwdata[2:0];
                ADDR_W'(`MCB_A_CTL4): s_d.check_exception_enable_bit = pwdata[`MCB_CTL4_MCE];
                default: s_d.check_exception_enable_bit = s_q.check_exception_enable_bit;
            endcase
        end
        // the raise wins over a software clear in the same cycle
        if (take) begin
            s_d.gstate[`MCB_GS_RIP] = err_restart_ok;
            s_d.gstate[`MCB_GS_EIP] = err_ip_related;
            s_d.gstate[`MCB_GS_CIP] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // zero wait states: every access completes in its first access cycle
    assign pready = psel & penable;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.slverr;
    assign check_vector = `MCB_VECTOR;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    logic hit0;
    assign hit0 = err_valid & (err_bank == '0);

    vector_fixed_a: assert property (check_exc |-> check_vector == 8'h12)
        else $error("exception not on vector 18");

    cap_count_a: assert property (setup && paddr == ADDR_W'(`MCB_A_CAP) |=> prdata[7:0] == NB8 && !pslverr)
        else $error("capability count wrong");

    bank_base_a: assert property (setup && paddr == (BASE | ADDR_W'(4)) |=> prdata == $past(bk_st[0]))
        else $error("bank zero state not at base plus four");

    good_set_a: assert property (hit0 && !bk_st[0][`MCB_ST_GOOD] && !bk_wr[0]
        |=> bk_st[0][`MCB_ST_GOOD] && bk_st[0][15:0] == $past(err_code))
        else $error("clean bank did not record error");

    nc_flag_a: assert property (hit0 && !bk_st[0][`MCB_ST_GOOD] && !bk_wr[0]
        |=> bk_st[0][`MCB_ST_NC] == !$past(err_corrected))
        else $error("not-corrected flag wrong");

    lost_set_a: assert property (hit0 && bk_st[0][`MCB_ST_GOOD] && !bk_wr[0] |=> bk_st[0][`MCB_ST_LOST])
        else $error("overflow not flagged");

    loc_flag_a: assert property (hit0 && !bk_st[0][`MCB_ST_GOOD] && !bk_wr[0]
        |=> bk_st[0][`MCB_ST_FAULT_LOCATION_PRESENT] == $past(err_addr_valid))
        else $error("location present flag wrong");

    no_corr_exc_a: assert property (err_valid && err_corrected |=> !check_exc)
        else $error("exception for corrected error");

    mce_gate_a: assert property (err_valid && !s_q.check_exception_enable_bit |=> !check_exc)
        else $error("exception while disabled");

    cip_set_a: assert property (check_exc |-> s_q.gstate[`MCB_GS_CIP])
        else $error("exception without check-in-progress");

    recurse_shut_a: assert property (any_raise && s_q.check_exception_enable_bit && s_q.gstate[`MCB_GS_CIP] |=> shutdown && !check_exc)
        else $error("recursion did not shut down");

    restart_flags_a: assert property (take |=> s_q.gstate[`MCB_GS_RIP] == $past(err_restart_ok)
        && s_q.gstate[`MCB_GS_EIP] == $past(err_ip_related))
        else $error("restart flags not captured");

    legacy_zero_a: assert property (setup && paddr == ADDR_W'(`MCB_A_LTYPE) |=> prdata == 32'h00000000)
        else $error("legacy type not zero");
endmodule

// >>> testbench/mcb_sw_model.sv
// behavioural handler and logging software that masters the apb port
`include "mcb_defines.svh"
module mcb_sw_model (
    input wire logic clk_sys,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ctx_seen = 1'b0;
    logic restart_ok = 1'b0;
    logic [15:0] last_code = 16'h0000;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data shows no stale word
        pwdata <= ~d;
    endtask
    task automatic log_bank(input int b, output logic gone);
        logic [31:0] s;
        logic [31:0] q;
        logic e;
        logic [11:0] a;
        a = `MCB_BANK_BASE + `MCB_BANK_STRIDE * 12'(b);
        xfer(1'b0, a + 12'h004, 32'h0, s, e);
        if (s[`MCB_ST_GOOD]) begin
            // only the code field is portable
            last_code = s[15:0];
            ctx_seen = s[`MCB_ST_PCC] | s[`MCB_ST_LOST];
            if (s[`MCB_ST_FAULT_LOCATION_PRESENT]) xfer(1'b0, a + 12'h008, 32'h0, q, e);
            if (s[`MCB_ST_EXTRA_INFO_PRESENT]) xfer(1'b0, a + 12'h00c, 32'h0, q, e);
            xfer(1'b1, a + 12'h004, 32'h0, q, e);
        end
        xfer(1'b0, a + 12'h004, 32'h0, s, e);
        gone = ~s[`MCB_ST_GOOD];
    endtask
    task automatic end_handler();
        logic [31:0] g;
        logic [31:0] q;
        logic e;
        xfer(1'b0, `MCB_A_GSTATE, 32'h0, g, e);
        restart_ok = ~ctx_seen & g[`MCB_GS_RIP];
        xfer(1'b1, `MCB_A_GSTATE, g & ~(32'h1 << `MCB_GS_CIP), q, e);
        ctx_seen = 1'b0;
    endtask
endmodule

// >>> testbench/mcb_machine_check_bench.sv
// self-checking bench with a model of the banks and global state
`include "mcb_defines.svh"
module mcb_machine_check_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, check_exc, shutdown, e, gone;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] check_vector;
    logic err_valid = 1'b0;
    logic [1:0] err_bank = 2'h0;
    logic [15:0] err_code = 16'h0000;
    logic err_corrected = 1'b0, err_ctx_corrupt = 1'b0, err_addr_valid = 1'b0;
    logic err_misc_valid = 1'b0, err_restart_ok = 1'b0, err_ip_related = 1'b0;
    logic [31:0] err_addr = 32'h0, err_misc = 32'h0;
    int n_errors = 0;
    int check_count = 0;
    logic [31:0] st [4];
    logic [31:0] ct [4];
    logic [31:0] ad [4];
    logic [31:0] mi [4];
    logic [2:0] gs = 3'h0;
    logic en = 1'b0;
    logic sh = 1'b0;
    mcb_machine_check mcb_machine_check_i (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .err_valid, .err_bank, .err_code, .err_corrected, .err_ctx_corrupt,
        .err_addr_valid, .err_addr, .err_misc_valid, .err_misc, .err_restart_ok, .err_ip_related,
        .check_exc, .check_vector, .shutdown);
    mcb_sw_model mcb_sw_model_i (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr);
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask
    function automatic logic [11:0] ba(input int b, input int r);
        return `MCB_BANK_BASE + `MCB_BANK_STRIDE * 12'(b) + 12'(4 * r);
    endfunction
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
        mcb_sw_model_i.xfer(1'b0, a, 32'h0, q, e);
        chk(n, q, x);
        chk("pslverr", {31'h0, e}, 32'h0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        mcb_sw_model_i.xfer(1'b1, a, d, q, e);
    endtask
    // f holds corrected, context corrupt, addr valid, misc valid, restart ok, ip related
    task automatic inj(input int b, input logic [15:0] c, input logic [5:0] f);
        logic [31:0] n;
        logic x;
        logic s;
        logic o;
        n = {2'b10, ~f[5], 1'b0, f[2], f[3], f[4], 9'h000, c};
        @(posedge clk_sys);
        err_valid <= 1'b1;
        err_bank <= 2'(b);
        err_code <= c;
        {err_corrected, err_ctx_corrupt, err_addr_valid, err_misc_valid, err_restart_ok, err_ip_related} <= f;
        err_addr <= $urandom;
        err_misc <= $urandom;
        @(posedge clk_sys);
        err_valid <= 1'b0;
        x = ~f[5] & ct[b][0] & en & ~sh;
        s = x & gs[2];
        // location and extra words follow the error only when it is the one kept
        o = ~st[b][31] | (~f[5] & ~st[b][29]);
        if (st[b][31]) st[b][30] = 1'b1;
        if (o) st[b] = n | {1'b0, st[b][30], 30'h0};
        if (o & f[3]) ad[b] = err_addr;
        if (o & f[2]) mi[b] = err_misc;
        sh = sh | s;
        if (x & ~s) gs = {1'b1, f[0], f[1]};
        #1;
        chk("check_exc", {31'h0, check_exc}, {31'h0, x & ~s});
        chk("shutdown", {31'h0, shutdown}, {31'h0, sh});
    endtask
    initial begin
        #100us;
        n_errors++;
        final_report();
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            st[i] = 32'h0;
            ct[i] = 32'h1;
            ad[i] = 32'h0;
            mi[i] = 32'h0;
        end
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        void'($urandom(32));
        chk("vector", {24'h0, check_vector}, 32'h12);
        rd(`MCB_A_CAP, 32'h4, "cap");
        rd(`MCB_A_LTYPE, 32'h0, "ltype");
        rd(`MCB_A_LLOC, 32'h0, "lloc");
        rd(`MCB_A_GSTATE, 32'h0, "gstate");
        for (int b = 0; b < 4; b++) begin
            rd(ba(b, 0), 32'h1, "bank ctl");
            rd(ba(b, 1), 32'h0, "bank status");
        end
        mcb_sw_model_i.xfer(1'b0, 12'h020, 32'h0, q, e);
        chk("unmapped", {31'h0, e}, 32'h1);
        mcb_sw_model_i.xfer(1'b0, 12'h402, 32'h0, q, e);
        chk("unaligned", {31'h0, e}, 32'h1);
        inj(0, 16'h0123, 6'b000000);
        rd(ba(0, 1), st[0], "status");
        mcb_sw_model_i.log_bank(0, gone);
        st[0] = 32'h0;
        chk("cleared", {31'h0, gone}, 32'h1);
        wr(`MCB_A_CTL4, 32'h1);
        en = 1'b1;
        rd(`MCB_A_CTL4, 32'h1, "ctl4");
        inj(1, 16'h0a5a, 6'b100000);
        rd(ba(1, 1), st[1], "status");
        inj(1, 16'h1111, 6'b100000);
        rd(ba(1, 1), st[1], "status");
        inj(1, 16'h2222, 6'b011110);
        rd(ba(1, 1), st[1], "status");
        rd(ba(1, 2), ad[1], "location");
        rd(ba(1, 3), mi[1], "extra");
        rd(`MCB_A_GSTATE, {29'h0, gs}, "gstate");
        mcb_sw_model_i.log_bank(1, gone);
        st[1] = 32'h0;
        mcb_sw_model_i.end_handler();
        gs[2] = 1'b0;
        chk("restart", {31'h0, mcb_sw_model_i.restart_ok}, 32'h0);
        inj(3, 16'h0303, 6'b000011);
        rd(`MCB_A_GSTATE, {29'h0, gs}, "gstate");
        mcb_sw_model_i.log_bank(3, gone);
        st[3] = 32'h0;
        mcb_sw_model_i.end_handler();
        gs[2] = 1'b0;
        chk("restart", {31'h0, mcb_sw_model_i.restart_ok}, 32'h1);
        // a bank with reporting off logs but stays quiet
        wr(ba(2, 0), 32'h0);
        ct[2] = 32'h0;
        inj(2, 16'h0202, 6'b000000);
        inj(0, 16'h0e0e, 6'b000000);
        inj(3, 16'h0f0f, 6'b000000);
        rd(ba(3, 1), st[3], "status");
        for (int i = 0; i < 12; i++) begin
            int b;
            b = $urandom % 4;
            inj(b, 16'($urandom), 6'b100000);
            rd(ba(b, 1), st[b], "status");
        end
        final_report();
    end
endmodule
